// [tcl_pkg.sv]
// Package of offsets, field positions, reset values and counts for the timer control-low block
package tcl_pkg;
   // Register byte addresses (word aligned)
   localparam logic [3:0] ADDR_CTRL_LOW = 4'h0;
   localparam logic [3:0] ADDR_COUNTER = 4'h4;
   localparam logic [3:0] ADDR_B_DATA = 4'h8;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'hC;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h0; // Word 4 at byte 0x10, decoded below on all five bits via ADDR_IRQ_MASK_FULL
   localparam logic [4:0] ADDR_IRQ_MASK_FULL = 5'h10;
   // Field positions in the control-low register
   localparam int FLD_TICK_SEL_LO = 5;
   localparam int FLD_IRQ_FLAG = 4;
   localparam int FLD_POLARITY = 2;
   localparam int FLD_EDGE_SEL = 1;
   localparam int FLD_SNAP_REQ = 0;
   // Reset values
   localparam logic [7:0] RST_CTRL_LOW = 8'h00;
   localparam logic [15:0] RST_B_DATA = 16'hFFFF;
   localparam logic [1:0] RST_IRQ_MASK = 2'h0;
   // Clock select codes and divider width
   localparam logic [2:0] SEL_EXTERNAL = 3'h7;
   localparam int DIV_WIDTH = 11;
   // Status bit positions: interrupt event and snapshot done
   localparam int ST_IRQ_EVENT = 0;
   localparam int ST_SNAP_DONE = 1;
   // Bus answer: cycles waitrequest stays high on a read
   localparam logic [1:0] BUS_WAIT_CYCLES = 2'h1;
endpackage : tcl_pkg

// [tcl_tick_sel.sv]
// Tick selection: prescaler taps and synchronised external pin edge
module tcl_tick_sel (
   input wire logic i_ref_clk, // System clock
   input wire logic i_rst, // Synchronous reset, active high
   input wire logic [2:0] i_sel, // Tick source select code
   input wire logic i_edge_rise, // 1 rising, 0 falling edge
   input wire logic i_ext_tick_pin, // External clock pin, asynchronous
   output logic o_tick // One-cycle count enable
);
   logic [tcl_pkg::DIV_WIDTH-1:0] div_reg;
   logic sync1_reg;
   logic sync2_reg;
   logic last_reg;
   logic tick_reg;
   logic [tcl_pkg::DIV_WIDTH-1:0] div_next;
   logic [7:0] taps;
   logic ext_edge;
   logic tick_next;

   // Free running prescaler; each tap pulses when its low bits are all ones
   assign div_next = div_reg + 1'b1;
   assign taps[0] = &div_reg[10:0];
   assign taps[1] = &div_reg[8:0];
   assign taps[2] = &div_reg[5:0];
   assign taps[3] = &div_reg[2:0];
   assign taps[4] = &div_reg[1:0];
   assign taps[5] = div_reg[0];
   assign taps[6] = 1'b1;
   // Edge found on the second stage only, never the first
   assign ext_edge = i_edge_rise ? (sync2_reg & ~last_reg) : (~sync2_reg & last_reg); // [RULE2] [RULE8]
   assign taps[7] = ext_edge;
   assign tick_next = taps[i_sel]; // [RULE1]

   // Prescaler, synchroniser and registered tick
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         div_reg <= '0;
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         last_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         sync1_reg <= i_ext_tick_pin;
         sync2_reg <= sync1_reg; // [RULE8]
         last_reg <= sync2_reg;
         tick_reg <= tick_next;
      end
   end

   assign o_tick = tick_reg;
endmodule : tcl_tick_sel

// [tcl_snap_mem.sv]
// Snapshot holder for the B data register, read data registered
module tcl_snap_mem (
   input wire logic i_ref_clk, // System clock
   input wire logic i_rst, // Synchronous reset, active high
   input wire logic i_load, // Load strobe
   input wire logic [15:0] i_data, // Value to hold
   output logic [15:0] o_data // Held value
);
   logic [15:0] data_reg;

   // Holds the counter copy until the next request
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         data_reg <= tcl_pkg::RST_B_DATA;
      end else if (i_load) begin
         data_reg <= i_data; // [RULE6]
      end
   end

   assign o_data = data_reg;
endmodule : tcl_snap_mem

// [tcl_ctrl_low.sv]
// Timer control-low fields: tick select, interrupt flag, polarity, snapshot, Avalon-MM slave
//
// Contract
// [RULE1] Select tick: /2048,/512,/64,/8,/4,/2,/1, external
// [RULE2] External edge: bit 0 falling, 1 rising
// [RULE3] Interrupt event sets the flag to one
// [RULE4] Flag cleared by writing zero or acknowledge
// [RULE5] Polarity sets output start and disabled level
// [RULE6] Writing one copies counter into B register
// [RULE7] Snapshot request bit self clears after copy
// [RULE8] Pin synchronised, edge gives one-cycle enable
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
module tcl_ctrl_low (
   input wire logic i_ref_clk, // System clock, 20 MHz
   input wire logic i_rst, // Synchronous reset, active high
   input wire logic [4:0] i_avs_address, // Byte address
   input wire logic i_avs_read, // Read request
   input wire logic i_avs_write, // Write request
   input wire logic [31:0] i_avs_writedata, // Write data
   input wire logic [3:0] i_avs_byteenable, // Byte enables
   output logic [31:0] o_avs_readdata, // Read data
   output logic o_avs_waitrequest, // Stall while high
   output logic o_avs_response_err, // Unmapped address answer
   input wire logic i_ext_tick_pin, // External tick pin, asynchronous
   input wire logic i_timer_enable, // Timer enable from mode logic
   input wire logic i_out_toggle, // Output toggle event (match)
   input wire logic i_irq_event, // Timer interrupt event
   input wire logic i_int_ack, // Interrupt controller acknowledge
   input wire logic [15:0] i_counter, // Live counter value
   output logic o_tick, // Counter tick enable
   output logic o_out_level, // Timer/PWM output level
   output logic o_irq_pending_flag, // Software flag to controller
   output logic o_snap_strobe, // Snapshot taken pulse
   output logic [15:0] o_b_data, // B data register value
   output logic o_irq // Level interrupt output
);
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [1:0] status_reg;
   logic [1:0] status_next;
   logic [1:0] mask_reg;
   logic out_reg;
   logic out_next;
   logic en_last_reg;
   logic snap_reg;
   logic irq_reg;
   logic [31:0] rdata_reg;
   logic ack_reg;
   logic wait_reg;
   logic err_reg;
   logic [15:0] b_data;

   // Address decode and handshake terms
   wire req = (i_avs_read | i_avs_write) & ~ack_reg;
   wire hit_ctrl = i_avs_address == {1'b0, tcl_pkg::ADDR_CTRL_LOW};
   wire hit_cnt = i_avs_address == {1'b0, tcl_pkg::ADDR_COUNTER};
   wire hit_b = i_avs_address == {1'b0, tcl_pkg::ADDR_B_DATA};
   wire hit_stat = i_avs_address == {1'b0, tcl_pkg::ADDR_IRQ_STATUS};
   wire hit_mask = i_avs_address == tcl_pkg::ADDR_IRQ_MASK_FULL;
   wire mapped = hit_ctrl | hit_cnt | hit_b | hit_stat | hit_mask;
   wire wr_ctrl = req & i_avs_write & hit_ctrl & i_avs_byteenable[0];
   wire wr_mask = req & i_avs_write & hit_mask & i_avs_byteenable[0];
   wire rd_stat = req & i_avs_read & hit_stat;
   wire [7:0] wd = i_avs_writedata[7:0];

   // Snapshot fires one cycle after the write, then the request bit drops
   wire snap_fire = ctrl_reg[tcl_pkg::FLD_SNAP_REQ]; // [RULE6]
   wire polarity = ctrl_reg[tcl_pkg::FLD_POLARITY];
   wire enable_rise = i_timer_enable & ~en_last_reg;

   // Control register next value; event set beats both clears
   always_comb begin
      ctrl_next = ctrl_reg;
      ctrl_next[3] = 1'b0;
      if (snap_fire) begin
         ctrl_next[tcl_pkg::FLD_SNAP_REQ] = 1'b0; // [RULE7]
      end
      if (wr_ctrl) begin
         ctrl_next[7:5] = wd[7:5];
         ctrl_next[tcl_pkg::FLD_POLARITY] = wd[tcl_pkg::FLD_POLARITY];
         ctrl_next[tcl_pkg::FLD_EDGE_SEL] = wd[tcl_pkg::FLD_EDGE_SEL];
         // Writing zero has no effect on the request
         if (wd[tcl_pkg::FLD_SNAP_REQ]) begin
            ctrl_next[tcl_pkg::FLD_SNAP_REQ] = 1'b1; // [RULE6]
         end
         // Writing one leaves the flag as it is; only zero clears
         if (!wd[tcl_pkg::FLD_IRQ_FLAG]) begin
            ctrl_next[tcl_pkg::FLD_IRQ_FLAG] = 1'b0; // [RULE4]
         end
      end
      if (i_int_ack) begin
         ctrl_next[tcl_pkg::FLD_IRQ_FLAG] = 1'b0; // [RULE4]
      end
      if (i_irq_event) begin
         ctrl_next[tcl_pkg::FLD_IRQ_FLAG] = 1'b1; // [RULE3]
      end
   end

   // Sticky status: read clears, a new event in the same cycle wins
   always_comb begin
      status_next = rd_stat ? 2'h0 : status_reg;
      if (i_irq_event) begin
         status_next[tcl_pkg::ST_IRQ_EVENT] = 1'b1;
      end
      if (snap_fire) begin
         status_next[tcl_pkg::ST_SNAP_DONE] = 1'b1;
      end
   end

   // Output level: disabled holds idle, enable start loads start level, match toggles
   always_comb begin
      out_next = out_reg;
      if (!i_timer_enable) begin
         out_next = polarity; // [RULE5]
      end else if (enable_rise) begin
         out_next = ~polarity; // [RULE5]
      end else if (i_out_toggle) begin
         out_next = ~out_reg;
      end
   end

   // Read data mux; unmapped reads return zero with an error answer
   wire [31:0] rdata_next =
      hit_ctrl ? {24'h000000, ctrl_reg} :
      hit_cnt ? {16'h0000, i_counter} :
      hit_b ? {16'h0000, b_data} :
      hit_stat ? {30'h0, status_reg} :
      hit_mask ? {30'h0, mask_reg} : 32'h00000000;

   // Register state
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ctrl_reg <= tcl_pkg::RST_CTRL_LOW;
         status_reg <= 2'h0;
         mask_reg <= tcl_pkg::RST_IRQ_MASK;
         out_reg <= 1'b0;
         en_last_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         status_reg <= status_next;
         out_reg <= out_next;
         en_last_reg <= i_timer_enable;
         if (wr_mask) begin
            mask_reg <= wd[1:0];
         end
      end
   end

   // Bus answer: one stall cycle, then waitrequest low for one edge
   // Waitrequest has its own flop so the pin never sees an inverter glitch
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ack_reg <= 1'b0;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
         err_reg <= 1'b0;
      end else begin
         ack_reg <= req;
         wait_reg <= ~req;
         if (req) begin
            rdata_reg <= i_avs_read ? rdata_next : 32'h00000000;
            err_reg <= ~mapped;
         end
      end
   end

   // Registered side outputs
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         snap_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         snap_reg <= snap_fire;
         irq_reg <= |(status_next & mask_reg);
      end
   end

   tcl_tick_sel u_tick (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_sel(ctrl_reg[7:5]),
      .i_edge_rise(ctrl_reg[tcl_pkg::FLD_EDGE_SEL]),
      .i_ext_tick_pin(i_ext_tick_pin),
      .o_tick(o_tick)
   );

   tcl_snap_mem u_snap (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_load(snap_fire),
      .i_data(i_counter),
      .o_data(b_data)
   );

   assign o_avs_readdata = rdata_reg;
   assign o_avs_waitrequest = wait_reg;
   assign o_avs_response_err = err_reg;
   assign o_out_level = out_reg;
   assign o_irq_pending_flag = ctrl_reg[tcl_pkg::FLD_IRQ_FLAG];
   assign o_snap_strobe = snap_reg;
   assign o_b_data = b_data;
   assign o_irq = irq_reg;
endmodule : tcl_ctrl_low

// [tcl_ctrl_low_monitor.sv]
// Port checker of the timer control-low block
module tcl_ctrl_low_chk (
   input wire logic i_ref_clk, // Clock
   input wire logic i_rst, // Reset
   input wire logic [4:0] i_avs_address, // Address
   input wire logic i_avs_read, // Read
   input wire logic i_avs_write, // Write
   input wire logic [31:0] i_avs_writedata, // Write data
   input wire logic [3:0] i_avs_byteenable, // Byte enables
   input wire logic o_avs_waitrequest, // Stall
   input wire logic i_irq_event, // Event
   input wire logic i_int_ack, // Acknowledge
   input wire logic i_timer_enable, // Enable
   input wire logic [15:0] i_counter, // Counter
   input wire logic o_out_level, // Output level
   input wire logic o_irq_pending_flag, // Flag
   input wire logic o_snap_strobe, // Snapshot pulse
   input wire logic [15:0] o_b_data // B data
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // Write of zero to the flag bit, taken at this edge
   wire wr0 = i_avs_write && o_avs_waitrequest && i_avs_address == 5'h00
      && i_avs_byteenable[0] && !i_avs_writedata[4];
   sequence s_clr;
      wr0 ##0 !i_irq_event;
   endsequence
   sequence s_req;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   AST_FLAG_SET: assert property (i_irq_event |=> o_irq_pending_flag)
      else $error("flag not set by event");
   AST_FLAG_WR: assert property (s_clr |=> !o_irq_pending_flag)
      else $error("flag not cleared by write");
   AST_FLAG_ACK: assert property (i_int_ack && !i_irq_event |=> !o_irq_pending_flag)
      else $error("flag not cleared by acknowledge");
   AST_FLAG_FELL: assert property ($fell(o_irq_pending_flag) |-> $past(i_int_ack) || $past(wr0))
      else $error("flag cleared without cause");
   AST_SNAP_LOAD: assert property (o_snap_strobe |-> o_b_data == $past(i_counter))
      else $error("B data differs from counter");
   AST_BDATA_CHG: assert property (!$stable(o_b_data) |-> o_snap_strobe)
      else $error("B data changed without snapshot");
   AST_OUT_START: assert property ($rose(i_timer_enable) |=> o_out_level != $past(o_out_level))
      else $error("output did not take start level");
   AST_WAIT_ANS: assert property (s_req |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer late or long");
endmodule : tcl_ctrl_low_chk

bind tcl_ctrl_low tcl_ctrl_low_chk u_tcl_ctrl_low_chk (.i_ref_clk, .i_rst, .i_avs_address,
   .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_waitrequest,
   .i_irq_event, .i_int_ack, .i_timer_enable, .i_counter, .o_out_level,
   .o_irq_pending_flag, .o_snap_strobe, .o_b_data);

// [tb.sv]
// Self-checking bench of the timer control-low block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
   logic [4:0] i_avs_address = 5'h00;
   logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
   logic [3:0] i_avs_byteenable = 4'hF;
   logic i_ext_tick_pin = 1'b0, i_timer_enable = 1'b0, i_out_toggle = 1'b0;
   logic i_irq_event = 1'b0, i_int_ack = 1'b0, er;
   logic [15:0] i_counter = 16'h0000, o_b_data, v;
   logic o_avs_waitrequest, o_avs_response_err, o_tick, o_out_level, o_irq_pending_flag;
   logic o_snap_strobe, o_irq;
   int n_mismatch = 0, total_checks = 0, n_tick = 0, t0, d, r;
   int sh[7] = '{11, 9, 6, 3, 2, 1, 0};
   tcl_ctrl_low u_tcl_ctrl_low (.i_ref_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
      .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
      .o_avs_response_err, .i_ext_tick_pin, .i_timer_enable, .i_out_toggle, .i_irq_event,
      .i_int_ack, .i_counter, .o_tick, .o_out_level, .o_irq_pending_flag, .o_snap_strobe,
      .o_b_data, .o_irq);
   // Clock and tick counter; ticks are counted where the pulse stands
   always #25 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) if (o_tick === 1'b1) n_tick <= n_tick + 1;
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One bus transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] dat);
      int k;
      @(posedge i_ref_clk);
      i_avs_address <= a;
      i_avs_writedata <= dat;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      k = 0;
      do begin
         @(posedge i_ref_clk);
         k++;
      end while (o_avs_waitrequest !== 1'b0 && k < 20);
      q = o_avs_readdata;
      er = o_avs_response_err;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      if (o_avs_waitrequest !== 1'b0) begin
         n_mismatch++;
         end_sim();
      end
   endtask : bus
   // One-cycle pulse on event (0), acknowledge (1) or toggle (2), then two edges
   task automatic pulse(input int w);
      if (w == 0) i_irq_event <= 1'b1;
      else if (w == 1) i_int_ack <= 1'b1;
      else i_out_toggle <= 1'b1;
      @(posedge i_ref_clk);
      i_irq_event <= 1'b0;
      i_int_ack <= 1'b0;
      i_out_toggle <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
   endtask : pulse
   function automatic logic [31:0] ctl(input int s, p, e, n);
      return 32'((s << 5) | (p << 2) | (e << 1) | n);
   endfunction : ctl
   // Ticks expected in a window of w cycles for divider code c
   function automatic int exp_ticks(input int c, input int w);
      return w >> sh[c];
   endfunction : exp_ticks
   initial begin
      void'($urandom(45));
      repeat (3) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      bus(1'b0, 5'h00, 32'h0);
      chk("ctrl reset", q, {24'h0, tcl_pkg::RST_CTRL_LOW});
      bus(1'b0, 5'h08, 32'h0);
      chk("b reset", q, {16'h0, tcl_pkg::RST_B_DATA});
      bus(1'b0, 5'h14, 32'h0);
      chk("unmapped err", er, 1);
      chk("unmapped data", q, 0);
      // Divided ticks over a fixed window, one tick of phase slack
      for (int c = 0; c < 7; c++) begin
         bus(1'b1, 5'h00, ctl(c, 0, 0, 0));
         repeat (4) @(posedge i_ref_clk);
         t0 = n_tick;
         repeat (4096) @(posedge i_ref_clk);
         d = n_tick - t0 - exp_ticks(c, 4096);
         chk("tick rate", d inside {-1, 0, 1}, 1);
      end
      // External pin, both edge settings, random hold times
      for (int e = 0; e < 2; e++) begin
         bus(1'b1, 5'h00, ctl(7, 0, e, 0));
         repeat (4) @(posedge i_ref_clk);
         repeat (3) begin
            r = 6 + $urandom_range(5);
            t0 = n_tick;
            i_ext_tick_pin <= 1'b1;
            repeat (r) @(posedge i_ref_clk);
            chk("rise ticks", n_tick - t0, e);
            t0 = n_tick;
            i_ext_tick_pin <= 1'b0;
            repeat (r) @(posedge i_ref_clk);
            chk("fall ticks", n_tick - t0, 1 - e);
         end
      end
      // Flag, sticky status, mask and interrupt line
      bus(1'b1, 5'h10, 32'h1);
      pulse(0);
      chk("irq on", o_irq, 1);
      bus(1'b1, 5'h00, 32'h10);
      bus(1'b0, 5'h00, 32'h0);
      chk("flag kept", q[4], 1);
      bus(1'b0, 5'h0C, 32'h0);
      chk("status", q[0], 1);
      repeat (2) @(posedge i_ref_clk);
      chk("irq off", o_irq, 0);
      bus(1'b1, 5'h00, 32'h0);
      bus(1'b0, 5'h00, 32'h0);
      chk("flag wr0", q[4], 0);
      bus(1'b1, 5'h10, 32'h0);
      pulse(0);
      chk("irq masked", o_irq, 0);
      chk("flag set", o_irq_pending_flag, 1);
      pulse(1);
      chk("flag ack", o_irq_pending_flag, 0);
      // Idle and start levels for both polarities
      for (int p = 0; p < 2; p++) begin
         bus(1'b1, 5'h00, ctl(6, p, 0, 0));
         repeat (2) @(posedge i_ref_clk);
         chk("idle level", o_out_level, p);
         i_timer_enable <= 1'b1;
         repeat (3) @(posedge i_ref_clk);
         chk("start level", o_out_level, 1 - p);
         // A match event while enabled flips the level once
         pulse(2);
         chk("toggle level", o_out_level, p);
         i_timer_enable <= 1'b0;
         repeat (2) @(posedge i_ref_clk);
      end
      // Snapshot of random counter values; a zero write changes nothing
      repeat (4) begin
         v = 16'($urandom);
         i_counter <= v;
         bus(1'b1, 5'h00, ctl(6, 0, 0, 1));
         i_counter <= ~v;
         @(posedge i_ref_clk);
         chk("snap strobe", o_snap_strobe, 1);
         bus(1'b0, 5'h00, 32'h0);
         chk("snap bit", q[0], 0);
         bus(1'b1, 5'h00, ctl(6, 0, 0, 0));
         bus(1'b0, 5'h08, 32'h0);
         chk("b data", q, {16'h0, v});
      end
      // Mid-run reset returns B data and control to their reset values
      i_rst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      bus(1'b0, 5'h08, 32'h0);
      chk("b reset again", q, {16'h0, tcl_pkg::RST_B_DATA});
      bus(1'b0, 5'h00, 32'h0);
      chk("ctrl reset again", q, {24'h0, tcl_pkg::RST_CTRL_LOW});
      end_sim();
   end
endmodule : tb
